// *** shared/pfm_pkg.sv ***
`default_nettype none
package pfm_pkg;
   localparam int GP_W = 24;
   localparam int PD_W = 5;
   localparam int PWM_HALF = 12;
   localparam int ALT_W = 2;
   localparam int IR_W = 4;
   localparam logic [ALT_W-1:0] ALT_GPIO = 2'h0;
   localparam logic [ALT_W-1:0] ALT_PWM = 2'h1;
   localparam logic [ALT_W-1:0] ALT_PORTD = 2'h2;
   localparam int PD_TDI = 0;
   localparam int PD_TDO = 1;
   localparam int PD_TCK = 2;
   localparam int PD_TMS = 3;
   localparam int PD_RST = 4;
   localparam logic PAD_RST = 1'b1;
   localparam logic FAULT_RST = 1'b0;
   localparam logic DIR_RST = 1'b0;
   localparam logic PER_RST = 1'b0;
   localparam logic WDOG_N_RST = 1'b1;
   localparam logic [IR_W-1:0] IR_RST = 4'h1;
   localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
   typedef enum logic [15:0] {
      pfm_tlr  = 16'h0001, pfm_rti  = 16'h0002, pfm_sdrs = 16'h0004, pfm_cdr  = 16'h0008,
      pfm_sdr  = 16'h0010, pfm_e1dr = 16'h0020, pfm_pdr  = 16'h0040, pfm_e2dr = 16'h0080,
      pfm_udr  = 16'h0100, pfm_sirs = 16'h0200, pfm_cir  = 16'h0400, pfm_sir  = 16'h0800,
      pfm_e1ir = 16'h1000, pfm_pir  = 16'h2000, pfm_e2ir = 16'h4000, pfm_uir  = 16'h8000
   } pfm_tap_t;
endpackage
`default_nettype wire

// *** hdl/pfm_tap.sv ***
`default_nettype none
module pfm_tap (
   input  wire logic core_clk,
   input  wire logic nrst,
   input  wire logic tap_enable,
   input  wire logic tck_rise,
   input  wire logic tck_fall,
   input  wire logic tms_s,
   input  wire logic tdi_s,
   output logic      tdo_q,
   output logic      tdo_en_q
);
   pfm_pkg::pfm_tap_t                 state_q;
   pfm_pkg::pfm_tap_t                 state_d;
   logic [pfm_pkg::IR_W-1:0]          ir_q;
   logic                              bypass_q;

   always_comb begin
      state_d = state_q;
      case (state_q)
         pfm_pkg::pfm_tlr:  state_d = tms_s ? pfm_pkg::pfm_tlr  : pfm_pkg::pfm_rti;
         pfm_pkg::pfm_rti:  state_d = tms_s ? pfm_pkg::pfm_sdrs : pfm_pkg::pfm_rti;
         pfm_pkg::pfm_sdrs: state_d = tms_s ? pfm_pkg::pfm_sirs : pfm_pkg::pfm_cdr;
         pfm_pkg::pfm_cdr:  state_d = tms_s ? pfm_pkg::pfm_e1dr : pfm_pkg::pfm_sdr;
         pfm_pkg::pfm_sdr:  state_d = tms_s ? pfm_pkg::pfm_e1dr : pfm_pkg::pfm_sdr;
         pfm_pkg::pfm_e1dr: state_d = tms_s ? pfm_pkg::pfm_udr  : pfm_pkg::pfm_pdr;
         pfm_pkg::pfm_pdr:  state_d = tms_s ? pfm_pkg::pfm_e2dr : pfm_pkg::pfm_pdr;
         pfm_pkg::pfm_e2dr: state_d = tms_s ? pfm_pkg::pfm_udr  : pfm_pkg::pfm_sdr;
         pfm_pkg::pfm_udr:  state_d = tms_s ? pfm_pkg::pfm_sdrs : pfm_pkg::pfm_rti;
         pfm_pkg::pfm_sirs: state_d = tms_s ? pfm_pkg::pfm_tlr  : pfm_pkg::pfm_cir;
         pfm_pkg::pfm_cir:  state_d = tms_s ? pfm_pkg::pfm_e1ir : pfm_pkg::pfm_sir;
         pfm_pkg::pfm_sir:  state_d = tms_s ? pfm_pkg::pfm_e1ir : pfm_pkg::pfm_sir;
         pfm_pkg::pfm_e1ir: state_d = tms_s ? pfm_pkg::pfm_uir  : pfm_pkg::pfm_pir;
         pfm_pkg::pfm_pir:  state_d = tms_s ? pfm_pkg::pfm_e2ir : pfm_pkg::pfm_pir;
         pfm_pkg::pfm_e2ir: state_d = tms_s ? pfm_pkg::pfm_uir  : pfm_pkg::pfm_sir;
         pfm_pkg::pfm_uir:  state_d = tms_s ? pfm_pkg::pfm_sdrs : pfm_pkg::pfm_rti;
         default:           state_d = pfm_pkg::pfm_tlr;
      endcase
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         state_q <= pfm_pkg::pfm_tlr;
      end else if (!tap_enable) begin
         state_q <= pfm_pkg::pfm_tlr;
      end else if (tck_rise) begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         ir_q     <= pfm_pkg::IR_RST;
         bypass_q <= 1'b0;
      end else if (tap_enable && tck_rise) begin
         if (state_q == pfm_pkg::pfm_cir) begin
            ir_q <= pfm_pkg::IR_CAPTURE;
         end else if (state_q == pfm_pkg::pfm_sir) begin
            ir_q <= {tdi_s, ir_q[pfm_pkg::IR_W-1:1]};
         end
         if (state_q == pfm_pkg::pfm_cdr) begin
            bypass_q <= 1'b0;
         end else if (state_q == pfm_pkg::pfm_sdr) begin
            bypass_q <= tdi_s;
         end
      end
   end

   // drive only in shift states, update on fall
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         tdo_q    <= 1'b0;
         tdo_en_q <= 1'b0;
      end else if (!tap_enable) begin
         tdo_en_q <= 1'b0;
      end else if (tck_fall) begin
         tdo_en_q <= (state_q == pfm_pkg::pfm_sir) || (state_q == pfm_pkg::pfm_sdr);
         tdo_q    <= (state_q == pfm_pkg::pfm_sir) ? ir_q[0] : bypass_q;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);

   tap_step_a: assert property ((state_q != $past(state_q)) && $past(tap_enable) |-> $past(tck_rise))
      else $error("tap state moved without a test clock rise");
   tdo_fall_a: assert property ($changed(tdo_en_q) && $past(tap_enable) |-> $past(tck_fall))
      else $error("test data output enable changed without a falling edge");
endmodule
`default_nettype wire

// *** hdl/pfm_pin_mux.sv ***
// Notes on behaviour
// - after reset every pin has its primary function; no alternate is active.
// - alternate routed only when peripheral enable and select field both choose it.
// - each port bit direction set or cleared alone, other bits untouched.
// - two pwm modules, four submodules, three pins each; output or capture.
// - fault inputs of a module force its masked pwm outputs inactive.
// - external watchdog output is low when asserted, high otherwise.
// - test data input is sampled on each test clock rise in shift-ir or shift-dr.
// - test mode select is sampled on each test clock rise to step the tap.
// - test data output driven only in shift-ir or shift-dr, else released.
// - test data output changes on the test clock falling edge.
// - test pins default to test functions; port d bits 0 to 3 alternately.
// - during reset test clock, mode select, data in are pulled-up inputs.
// - reset pin as port d bit 4 is input or open drain; pin reset off.
`default_nettype none
module pfm_pin_mux #(
   parameter int GP_W = pfm_pkg::GP_W,
   parameter int PD_W = pfm_pkg::PD_W
) (
   input  wire logic                   core_clk,
   input  wire logic                   nrst,
   input  wire logic [GP_W+PD_W-1:0]   pad_in,
   output logic      [GP_W+PD_W-1:0]   pad_out,
   output logic      [GP_W+PD_W-1:0]   pad_oe,
   output logic      [GP_W+PD_W-1:0]   pad_pu,
   input  wire logic                   cfg_per_wr,
   input  wire logic [GP_W+PD_W-1:0]   cfg_per_wdata,
   input  wire logic                   cfg_sel_wr,
   input  wire logic [2*(GP_W+PD_W)-1:0] pin_alt_select_reg,
   input  wire logic [GP_W+PD_W-1:0]   dir_set,
   input  wire logic [GP_W+PD_W-1:0]   dir_clr,
   output logic      [GP_W+PD_W-1:0]   gpio_dir,
   input  wire logic [GP_W+PD_W-1:0]   gpio_dout,
   output logic      [GP_W+PD_W-1:0]   gpio_din,
   input  wire logic [GP_W-1:0]        pwm_out,
   input  wire logic [GP_W-1:0]        pwm_cap_mode,
   output logic      [GP_W-1:0]        pwm_cap_in,
   input  wire logic [GP_W-1:0]        pwm_fault_mask,
   input  wire logic                   pwm_a_fault_in0,
   input  wire logic                   pwm_a_fault_in1,
   input  wire logic                   pwm_b_fault_in0,
   input  wire logic                   pwm_b_fault_in1,
   input  wire logic                   wdog_assert,
   output logic                        ext_watchdog_out_n,
   output logic                        pin_reset_req
);
   localparam int NP = GP_W + PD_W;
   localparam int SW = NP + 4;
   localparam int TDI = GP_W + pfm_pkg::PD_TDI;
   localparam int TDO = GP_W + pfm_pkg::PD_TDO;
   localparam int TCK = GP_W + pfm_pkg::PD_TCK;
   localparam int TMS = GP_W + pfm_pkg::PD_TMS;
   localparam int RST = GP_W + pfm_pkg::PD_RST;
   localparam logic [SW-1:0] SYNC_RST = {{4{pfm_pkg::FAULT_RST}}, {NP{pfm_pkg::PAD_RST}}};

   logic [SW-1:0]          s1_q, s2_q, s3_q, st_q;
   logic [NP-1:0]          per_q, dir_q;
   logic [2*NP-1:0]        sel_q;
   logic [NP-1:0]          alt;
   logic [NP-1:0]          out_d, oe_d, pu_d;
   logic [GP_W-1:0]        cap_d, kill;
   logic                   tck_prev_q, tck_rise, tck_fall;
   logic                   tdo_val, tdo_en, fault_a, fault_b, wrote_q;

   function automatic logic [pfm_pkg::ALT_W-1:0] sel_of(input logic [2*NP-1:0] s, input int i);
      sel_of = s[2*i +: pfm_pkg::ALT_W];
   endfunction

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         s1_q <= SYNC_RST;
         s2_q <= SYNC_RST;
         s3_q <= SYNC_RST;
         st_q <= SYNC_RST;
      end else begin
         s1_q <= {pwm_b_fault_in1, pwm_b_fault_in0, pwm_a_fault_in1, pwm_a_fault_in0, pad_in};
         s2_q <= s1_q;
         s3_q <= s2_q;
         st_q <= (s2_q & s3_q) | (st_q & (s2_q | s3_q));
      end
   end

   // enables and selects clear at reset
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         per_q   <= {NP{pfm_pkg::PER_RST}};
         sel_q   <= {(2*NP){1'b0}};
         wrote_q <= 1'b0;
      end else begin
         if (cfg_per_wr) begin
            per_q <= cfg_per_wdata;
         end
         if (cfg_sel_wr) begin
            sel_q <= pin_alt_select_reg;
         end
         if (cfg_per_wr || cfg_sel_wr) begin
            wrote_q <= 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         dir_q <= {NP{pfm_pkg::DIR_RST}};
      end else begin
         dir_q <= (dir_q & ~dir_clr) | dir_set;
      end
   end

   // edges of the probe test clock
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         tck_prev_q <= pfm_pkg::PAD_RST;
      end else begin
         tck_prev_q <= st_q[TCK];
      end
   end
   assign tck_rise = st_q[TCK] & ~tck_prev_q;
   assign tck_fall = ~st_q[TCK] & tck_prev_q;

   pfm_tap u_pfm_tap (
      .core_clk  (core_clk),
      .nrst      (nrst),
      .tap_enable(~alt[TCK]),
      .tck_rise  (tck_rise),
      .tck_fall  (tck_fall),
      .tms_s     (alt[TMS] | st_q[TMS]),
      .tdi_s     (alt[TDI] | st_q[TDI]),
      .tdo_q     (tdo_val),
      .tdo_en_q  (tdo_en)
   );

   // faults kill masked outputs of their module
   assign fault_a = st_q[NP] | st_q[NP+1];
   assign fault_b = st_q[NP+2] | st_q[NP+3];
   always_comb begin
      for (int i = 0; i < GP_W; i++) begin
         kill[i] = pwm_fault_mask[i] & ((i < pfm_pkg::PWM_HALF) ? fault_a : fault_b);
      end
   end

   // alternate needs both enable and select
   always_comb begin
      for (int i = 0; i < NP; i++) begin
         alt[i] = per_q[i] && (sel_of(sel_q, i) == ((i < GP_W) ? pfm_pkg::ALT_PWM : pfm_pkg::ALT_PORTD));
      end
   end

   always_comb begin
      out_d = gpio_dout;
      oe_d  = dir_q;
      pu_d  = ~dir_q;
      cap_d = '0;
      for (int i = 0; i < GP_W; i++) begin
         if (alt[i]) begin
            oe_d[i]  = ~pwm_cap_mode[i];
            out_d[i] = pwm_out[i] & ~kill[i];
            pu_d[i]  = 1'b0;
            cap_d[i] = pwm_cap_mode[i] & st_q[i];
         end
      end
      // test functions are primary, inputs pulled up
      for (int j = GP_W; j < NP; j++) begin
         if (!alt[j]) begin
            oe_d[j]  = 1'b0;
            out_d[j] = 1'b0;
            pu_d[j]  = 1'b1;
         end
      end
      if (!alt[TDO]) begin
         oe_d[TDO]  = tdo_en;
         out_d[TDO] = tdo_val;
         pu_d[TDO]  = 1'b0;
      end
      // open drain port d bit 4
      if (alt[RST]) begin
         oe_d[RST]  = dir_q[RST] & ~gpio_dout[RST];
         out_d[RST] = 1'b0;
         pu_d[RST]  = 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         pad_out    <= '0;
         pad_oe     <= '0;
         pad_pu     <= '1;
         pwm_cap_in <= '0;
         gpio_din   <= {NP{pfm_pkg::PAD_RST}};
      end else begin
         pad_out    <= out_d;
         pad_oe     <= oe_d;
         pad_pu     <= pu_d;
         pwm_cap_in <= cap_d;
         gpio_din   <= st_q[NP-1:0];
      end
   end
   assign gpio_dir = dir_q;

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         ext_watchdog_out_n <= pfm_pkg::WDOG_N_RST;
      end else begin
         ext_watchdog_out_n <= ~wdog_assert;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         pin_reset_req <= 1'b0;
      end else begin
         pin_reset_req <= ~alt[RST] & ~st_q[RST];
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);

   reset_primary_a: assert property (!wrote_q |-> (per_q == '0) && (sel_q == '0) && (pad_oe[GP_W-1:0] == $past(dir_q[GP_W-1:0])))
      else $error("alternate function active before any selection");
   alt_route_a: assert property (alt[0] && !pwm_cap_mode[0] && !kill[0] |=> pad_out[0] == $past(pwm_out[0]))
      else $error("pwm output not routed to pin 0");
   dir_single_a: assert property ($onehot(dir_set) && (dir_clr == '0) |=> dir_q == ($past(dir_q) | $past(dir_set)))
      else $error("direction update disturbed other bits");
   capture_in_a: assert property (alt[0] && pwm_cap_mode[0] |=> !pad_oe[0] && (pwm_cap_in[0] == $past(st_q[0])))
      else $error("capture pin not released or not sampled");
   fault_kill_a: assert property (alt[0] && pwm_fault_mask[0] && fault_a |=> !pad_out[0])
      else $error("fault did not disable pwm output");
   wdog_low_a: assert property (wdog_assert |=> !ext_watchdog_out_n)
      else $error("watchdog output not low when asserted");
   tdo_drive_a: assert property (!alt[TDO] |=> pad_oe[TDO] == $past(tdo_en))
      else $error("test data output drive mismatch");
   test_pullup_a: assert property (!alt[TCK] && !alt[TMS] && !alt[TDI] |=> pad_pu[TCK] && pad_pu[TMS] && pad_pu[TDI])
      else $error("test input pins lost pull-up");
   rst_pin_off_a: assert property (alt[RST] |=> !pin_reset_req && !pad_out[RST])
      else $error("reassigned reset pin still resets or drives high");
   gpio_owns_a: assert property (!per_q[1] |=> pad_oe[1] == $past(dir_q[1]))
      else $error("disabled peripheral pin not under port control");

   pwm_out_c: cover property (alt[0] && !pwm_cap_mode[0] ##1 pad_oe[0]);
   shift_c: cover property (tdo_en ##1 pad_oe[TDO]);
   portd_c: cover property (alt[TDI] && alt[TMS] && alt[TCK]);
   fault_c: cover property (fault_a && fault_b);
endmodule
`default_nettype wire

// *** test/pfm_probe.sv ***
`default_nettype none
module pfm_probe (
   input  wire logic core_clk,
   output logic      tck,
   output logic      tms,
   output logic      tdi
);
   timeunit 1ns;
   timeprecision 1ps;
   logic drv;
   logic tck_d;
   logic tms_d;
   logic tdi_d;
   initial begin
      drv = 1'h0;
      tck_d = 1'h0;
      tms_d = 1'h1;
      tdi_d = 1'h1;
   end
   assign tck = drv ? tck_d : 1'h1;
   assign tms = drv ? tms_d : 1'h1;
   assign tdi = drv ? tdi_d : 1'h1;
   // data set up, held over rise
   task automatic rise(input logic m, input logic d);
      @(posedge core_clk);
      drv <= 1'h1;
      tms_d <= m;
      tdi_d <= d;
      repeat (8) @(posedge core_clk);
      tck_d <= 1'h1;
      repeat (8) @(posedge core_clk);
   endtask
   task automatic fall();
      @(posedge core_clk);
      tck_d <= 1'h0;
      repeat (8) @(posedge core_clk);
   endtask
   task automatic release_port();
      @(posedge core_clk);
      drv <= 1'h0;
   endtask
endmodule
`default_nettype wire

// *** test/pin_function_mux_test_port_tb.sv ***
`default_nettype none
module pin_function_mux_test_port_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int N = pfm_pkg::GP_W + pfm_pkg::PD_W;
   localparam int M = 2 * N;
   logic           core_clk, nrst, cfg_per_wr, cfg_sel_wr, wdog_assert, ext_watchdog_out_n, pin_reset_req, rt;
   logic           pwm_a_fault_in0, pwm_a_fault_in1, pwm_b_fault_in0, pwm_b_fault_in1, tck, tms, tdi;
   logic [N-1:0]   pad_in, pad_out, pad_oe, pad_pu, pin_lv, ext, cfg_per_wdata, dir_set, dir_clr;
   logic [N-1:0]   gpio_dir, gpio_dout, gpio_din, exp_q[$], got_q[$];
   logic [M-1:0]   pin_alt_select_reg, s;
   logic [23:0]    pwm_out, pwm_cap_mode, pwm_cap_in, pwm_fault_mask, eo, eout, ec;
   logic [31:0]    r, cm, lv, per;
   int             failures, n_checks, b, c, p, q;
   assign ext = {pin_lv[28], tms, tck, 1'h1, tdi, pin_lv[23:0]};
   assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext);
   pfm_pin_mux u_pfm_pin_mux (.core_clk, .nrst, .pad_in, .pad_out, .pad_oe, .pad_pu, .cfg_per_wr,
      .cfg_per_wdata, .cfg_sel_wr, .pin_alt_select_reg, .dir_set, .dir_clr, .gpio_dir, .gpio_dout,
      .gpio_din, .pwm_out, .pwm_cap_mode, .pwm_cap_in, .pwm_fault_mask, .pwm_a_fault_in0,
      .pwm_a_fault_in1, .pwm_b_fault_in0, .pwm_b_fault_in1, .wdog_assert, .ext_watchdog_out_n,
      .pin_reset_req);
   pfm_probe u_pfm_probe (.core_clk, .tck, .tms, .tdi);
   initial begin
      core_clk = 1'h0;
      forever #20 core_clk = ~core_clk;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic chk(input logic [N-1:0] got, input logic [N-1:0] exp);
      got_q.push_back(got);
      exp_q.push_back(exp);
   endtask
   always begin
      wait (got_q.size() > 0);
      n_checks++;
      if (got_q[0] !== exp_q[0]) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got_q[0], exp_q[0]);
      end
      void'(got_q.pop_front());
      void'(exp_q.pop_front());
   end
   task automatic results();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic wait_on(input int w, input int i, input logic val);
      logic [N-1:0] v;
      for (int k = 0; k < 12; k++) begin
         #1;
         v = w ? N'(pin_reset_req) : pad_out;
         if (v[i] === val)
            return;
         @(posedge core_clk);
      end
      failures++;
      $display("mismatch at %0t: wait expired", $time);
      results();
   endtask
   task automatic cfg(input logic [N-1:0] pv, input logic [M-1:0] sv);
      @(posedge core_clk);
      cfg_per_wr <= 1'h1;
      cfg_per_wdata <= pv;
      cfg_sel_wr <= 1'h1;
      pin_alt_select_reg <= sv;
      tick(1);
      cfg_per_wr <= 1'h0;
      cfg_sel_wr <= 1'h0;
      tick(2);
   endtask
   initial begin
      {nrst, cfg_per_wr, cfg_sel_wr, wdog_assert, cfg_per_wdata, pin_alt_select_reg} = '0;
      {dir_set, dir_clr, gpio_dout, pwm_out, pwm_cap_mode, pwm_fault_mask} = '0;
      {pwm_a_fault_in0, pwm_a_fault_in1, pwm_b_fault_in0, pwm_b_fault_in1} = 4'h0;
      pin_lv = '1;
      void'($urandom(32'hD39F));
      tick(2);
      #1 chk(pad_pu & pad_oe, '0);
      chk(pad_pu, '1);
      tick(6);
      nrst <= 1'h1;
      tick(3);
      #1 chk(pad_oe, '0);
      chk(N'(ext_watchdog_out_n), N'(1));
      chk(pad_pu, ~(N'(1) << 25));
      for (int k = 0; k < 4; k++) begin
         u_pfm_probe.rise(k == 1, 1'h0);
         u_pfm_probe.fall();
         #1 chk(N'(pad_oe[25]), N'(k == 3));
      end
      u_pfm_probe.rise(1'h0, 1'h1);
      #1 chk(N'({pad_oe[25], pad_out[25]}), N'(2'h2));
      u_pfm_probe.fall();
      #1 chk(N'({pad_oe[25], pad_out[25]}), N'(2'h3));
      u_pfm_probe.rise(1'h1, 1'h0);
      u_pfm_probe.fall();
      #1 chk(N'(pad_oe[25]), N'(0));
      u_pfm_probe.release_port();
      b = $urandom_range(28);
      c = (b + 1 + $urandom_range(27)) % 29;
      tick(1);
      dir_set <= N'(1) << b;
      tick(1);
      dir_set <= N'(1) << c;
      tick(1);
      dir_set <= '0;
      dir_clr <= N'(1) << b;
      #1 chk(gpio_dir, (N'(1) << b) | (N'(1) << c));
      tick(1);
      dir_clr <= '0;
      #1 chk(gpio_dir, N'(1) << c);
      tick(1);
      dir_set <= '1;
      for (int t = 0; t < 4; t++) begin
         r = $urandom;
         cm = t > 1 ? $urandom : 0;
         lv = $urandom;
         per = $urandom;
         s = M'({$urandom, $urandom});
         tick(1);
         dir_set <= '0;
         pwm_out <= r[23:0];
         gpio_dout <= N'(~r);
         pwm_cap_mode <= cm[23:0];
         pin_lv <= N'(lv);
         for (int i = 0; i < 24; i++) begin
            rt = per[i] && s[2*i +: 2] == 2'h1;
            eo[i] = rt ? ~cm[i] : 1'h1;
            eout[i] = rt ? r[i] : ~r[i];
            ec[i] = rt & cm[i] & lv[i];
         end
         cfg(N'(per[23:0]), s);
         tick(6);
         #1 chk(N'(pad_oe[23:0]), N'(eo));
         chk(N'(pad_out[23:0] & eo), N'(eout & eo));
         chk(N'(pwm_cap_in), N'(ec));
         chk(N'(gpio_din[23:0]), N'((eout & eo) | (lv[23:0] & ~eo)));
      end
      tick(1);
      pwm_out <= '1;
      pwm_cap_mode <= '0;
      pwm_fault_mask <= '1;
      cfg(N'(24'hFFFFFF), M'({24{2'h1}}));
      for (int f = 0; f < 4; f++) begin
         p = (f < 2 ? 0 : 12) + $urandom_range(11);
         q = (f < 2 ? 12 : 0) + $urandom_range(11);
         tick(1);
         {pwm_b_fault_in1, pwm_b_fault_in0, pwm_a_fault_in1, pwm_a_fault_in0} <= 4'h1 << f;
         wait_on(0, p, 1'h0);
         chk(N'({pad_out[p], pad_out[q]}), N'(2'h1));
         tick(1);
         {pwm_b_fault_in1, pwm_b_fault_in0, pwm_a_fault_in1, pwm_a_fault_in0} <= 4'h0;
         wait_on(0, p, 1'h1);
      end
      tick(1);
      wdog_assert <= 1'h1;
      tick(1);
      #1 chk(N'(ext_watchdog_out_n), N'(0));
      tick(1);
      wdog_assert <= 1'h0;
      pin_lv[28] <= 1'h0;
      tick(1);
      #1 chk(N'(ext_watchdog_out_n), N'(1));
      wait_on(1, 0, 1'h1);
      r = $urandom & 32'hEFFFFFFF;
      tick(1);
      gpio_dout <= N'(r);
      cfg(N'(29'h1F000000), {10'h2AA, 48'h0});
      tick(4);
      #1 chk(N'({pad_oe[28:24], pad_out[28:24], pin_reset_req}), N'({5'h1F, 1'h0, r[27:24], 1'h0}));
      tick(1);
      gpio_dout <= N'(r | 32'h10000000);
      tick(3);
      #1 chk(N'({pad_oe[28], pin_reset_req}), N'(0));
      tick(2);
      results();
   end
endmodule
`default_nettype wire
